/* shared/dacpc_map.svh */
// offsets, field positions, reset values and counts of the converter control
// assumes an APB slave with byte addresses and 32-bit data
`ifndef DACPC_MAP_SVH
`define DACPC_MAP_SVH
`define DACPC_ADDR_W          12
`define DACPC_ADDR_CTRL       12'h000
`define DACPC_ADDR_STATUS     12'h004
`define DACPC_CTRL_RESET      6'h00
`define DACPC_CTRL_W          6
`define DACPC_ST_CAL_RUN      0
`define DACPC_ST_PWR_DOWN     1
`define DACPC_ST_Q_DOWN       2
`define DACPC_ST_Q_CAL_OK     3
`define DACPC_ST_DES          4
`define DACPC_ST_TRIM_LSB     8
`define DACPC_PIPE_DEPTH      14
`define DACPC_PRI_TAP         12
`define DACPC_DLY_TAP         13
`define DACPC_CAL_PIN_CYCLES  8'h50
`define DACPC_PWRUP_SHORT     32'h0200_0000
`define DACPC_PWRUP_LONG      32'h8000_0000
`define DACPC_CAL_LEN         32'h0000_0400
`define DACPC_TRIM_MID        6'h20
`define DACPC_ACC_LIMIT       8'h10
`endif

/* shared/dacpc_pkg.sv */
// types shared by the converter control files
// assumes dacpc_map.svh for all numeric values
package dacpc_pkg;
  typedef struct packed {
    logic out_level;
    logic out_edge;
    logic ddr;
    logic bg_en;
    logic des_q_sel;
    logic des_en;
  } dacpc_cfg_t;

  typedef struct packed {
    logic       sample_clk;
    logic [7:0] i_sample;
    logic [7:0] q_sample;
    logic       ext_control;
    logic       output_edge_select;
    logic       output_edge_float;
    logic       output_level_select;
    logic       des_select;
    logic       power_down_input;
    logic       q_power_down_input;
    logic       cal_input;
    logic       power_up_delay_select;
  } dacpc_pins_t;

  typedef struct packed {
    logic [7:0] i_primary_bus;
    logic [7:0] i_delayed_bus;
    logic [7:0] q_primary_bus;
    logic [7:0] q_delayed_bus;
  } dacpc_bus_t;

  typedef enum logic [1:0] {
    DACPC_ST_DELAY,
    DACPC_ST_IDLE,
    DACPC_ST_CAL
  } dacpc_cal_st_t;
endpackage : dacpc_pkg

/* hw/dacpc_sync.sv */
// two-stage synchroniser for a group of pin inputs
// assumes inputs are asynchronous to i_clk
`timescale 1ns/100ps
`default_nettype none
module dacpc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_reg <= '0;
      o_sync   <= '0;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule : dacpc_sync
`default_nettype wire

/* hw/dacpc_phase_track.sv */
// background tracker of the rise/fall converter clock phase
// assumes a one-cycle strobe per sample-clock period
`timescale 1ns/100ps
`include "dacpc_map.svh"
`default_nettype none
module dacpc_phase_track (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_enable,
  input  wire logic       i_strobe,
  input  wire logic [7:0] i_rise_sample,
  input  wire logic [7:0] i_fall_sample,
  output var  logic [5:0] o_trim
);
  logic signed [7:0] acc_reg;
  logic              rise_high;

  assign rise_high = i_rise_sample > i_fall_sample;

  // a persistent bias between the two halves walks the trim one step
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      acc_reg <= '0;
      o_trim  <= `DACPC_TRIM_MID;
    end
    else if (i_enable && i_strobe)
    begin
      if (acc_reg == $signed(`DACPC_ACC_LIMIT))
      begin
        acc_reg <= '0;
        o_trim  <= o_trim - 6'h01;
      end
      else if (acc_reg == -$signed(`DACPC_ACC_LIMIT))
      begin
        acc_reg <= '0;
        o_trim  <= o_trim + 6'h01;
      end
      else if (rise_high)
        acc_reg <= acc_reg + 8'sh01;
      else
        acc_reg <= acc_reg - 8'sh01;
    end
  end
endmodule : dacpc_phase_track
`default_nettype wire

/* hw/dacpc_top.sv */
// output demultiplexing, output clocking, power-down and calibration control
// assumes pins asynchronous to i_clk, sample clock well below i_clk / 4
//
// Notes on behaviour
// - in dual-edge mode one converter samples on rise, other on fall
// - dual-edge outputs form 1:4 demux, order delayed-Q, delayed-I, Q, I
// - normal mode primary buses at 13 cycles, delayed buses at 14
// - dual-edge Q buses carry rise samples at 13.5 and 14.5 cycles
// - pin control samples I in dual-edge; register control picks input
// - optional background tracking of I/Q clock phase in dual-edge mode
// - single rate, edge select high moves data on clock rise, else fall
// - single rate clock equals word rate; double rate half, both edges
// - under pin control a floating edge select chooses double rate
// - power-down high holds output buses at last conversion
// - Q power-down stops only Q; I channel keeps running
// - power-down during calibration waits for calibration to finish
// - power-down high at power-up holds off power-up delay and calibration
// - calibration request while powered down is dropped, not remembered
// - calibration runs with Q down but skips Q; recalibrate before Q use
// - calibration running output high during every calibration
// - power-up delay before calibration is 2^25 or 2^31 sample cycles
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`include "dacpc_map.svh"
`default_nettype none
module dacpc_top #(
  parameter logic [31:0] P_PWRUP_SHORT = `DACPC_PWRUP_SHORT,
  parameter logic [31:0] P_PWRUP_LONG  = `DACPC_PWRUP_LONG,
  parameter logic [31:0] P_CAL_LEN     = `DACPC_CAL_LEN
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [`DACPC_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output var  logic [31:0]              o_prdata,
  output var  logic                     o_pready,
  output var  logic                     o_pslverr,
  input  wire dacpc_pkg::dacpc_pins_t   i_pins,
  output var  dacpc_pkg::dacpc_bus_t    o_buses,
  output var  logic                     o_forwarded_data_clock,
  output var  logic                     o_output_level_select,
  output var  logic                     o_calibration_running,
  output var  logic [5:0]               o_phase_trim
);
  dacpc_pkg::dacpc_pins_t  pin_s;
  dacpc_pkg::dacpc_cfg_t   ctrl_reg;
  dacpc_pkg::dacpc_cal_st_t st_reg;
  logic        sclk_d_reg;
  logic        fall_ev;
  logic        rise_ev;
  logic        des;
  logic        sel_q;
  logic        ddr;
  logic        out_edge;
  logic        bg_en;
  logic        pwr_off_reg;
  logic        q_down;
  logic        q_cal_ok_reg;
  logic [31:0] cnt_reg;
  logic [31:0] pwrup_lim;
  logic [7:0]  low_cnt_reg;
  logic [7:0]  high_cnt_reg;
  logic        cal_req;
  logic [7:0]  rise_hold_reg;
  logic [7:0]  i_in;
  logic [7:0]  q_in;
  logic [7:0]  pipe_i [`DACPC_PIPE_DEPTH];
  logic [7:0]  pipe_q [`DACPC_PIPE_DEPTH];
  logic [5:0]  trim;
  logic        apb_done;
  logic [31:0] status_word;

  dacpc_sync #(
    .W ($bits(dacpc_pkg::dacpc_pins_t))
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_pins),
    .o_sync  (pin_s)
  );

  // edges found on the synchronised sample clock only
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      sclk_d_reg <= 1'b0;
    else
      sclk_d_reg <= pin_s.sample_clk;
  end

  assign fall_ev = sclk_d_reg & ~pin_s.sample_clk;
  assign rise_ev = ~sclk_d_reg & pin_s.sample_clk;

  // pin control or register control, fixed per system
  always_comb
  begin
    if (pin_s.ext_control)
    begin
      des      = ctrl_reg.des_en;
      sel_q    = ctrl_reg.des_q_sel;
      ddr      = ctrl_reg.ddr;
      out_edge = ctrl_reg.out_edge;
      bg_en    = ctrl_reg.bg_en;
    end
    else
    begin
      des      = pin_s.des_select;
      sel_q    = 1'b0;
      ddr      = pin_s.output_edge_float;
      out_edge = pin_s.output_edge_select;
      bg_en    = 1'b1;
    end
  end

  assign q_down    = pin_s.q_power_down_input | pwr_off_reg;
  assign pwrup_lim = (pin_s.power_up_delay_select && !pin_s.ext_control)
                     ? P_PWRUP_LONG : P_PWRUP_SHORT;

  // power-down is taken only outside calibration
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      pwr_off_reg <= 1'b0;
    else if (!pin_s.power_down_input)
      pwr_off_reg <= 1'b0;
    else if (st_reg != dacpc_pkg::DACPC_ST_CAL)
      pwr_off_reg <= 1'b1;
  end

  // command detector counts sample-clock periods; cleared while powered
  // down so nothing half-seen survives into the active state
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      low_cnt_reg  <= '0;
      high_cnt_reg <= '0;
    end
    else if (pwr_off_reg || pin_s.power_down_input)
    begin
      low_cnt_reg  <= '0;
      high_cnt_reg <= '0;
    end
    else if (fall_ev)
    begin
      if (!pin_s.cal_input)
      begin
        high_cnt_reg <= '0;
        if (low_cnt_reg != `DACPC_CAL_PIN_CYCLES)
          low_cnt_reg <= low_cnt_reg + 8'h01;
      end
      else if (low_cnt_reg == `DACPC_CAL_PIN_CYCLES)
      begin
        if (cal_req)
        begin
          low_cnt_reg  <= '0;
          high_cnt_reg <= '0;
        end
        else
          high_cnt_reg <= high_cnt_reg + 8'h01;
      end
      else
        low_cnt_reg <= '0;
    end
  end

  // pin gate too: the request must not slip in while power-down settles
  assign cal_req = fall_ev && pin_s.cal_input && !pwr_off_reg
                   && !pin_s.power_down_input
                   && low_cnt_reg == `DACPC_CAL_PIN_CYCLES
                   && high_cnt_reg == `DACPC_CAL_PIN_CYCLES - 8'h01;

  // power-up delay, then calibration; counts sample-clock periods
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg                <= dacpc_pkg::DACPC_ST_DELAY;
      cnt_reg               <= '0;
      o_calibration_running <= 1'b0;
    end
    else
    begin
      case (st_reg)
        dacpc_pkg::DACPC_ST_DELAY:
        begin
          if (fall_ev && !pin_s.power_down_input)
          begin
            if (cnt_reg == pwrup_lim - 32'h1)
            begin
              cnt_reg               <= '0;
              st_reg                <= dacpc_pkg::DACPC_ST_CAL;
              o_calibration_running <= 1'b1;
            end
            else
              cnt_reg <= cnt_reg + 32'h1;
          end
        end
        dacpc_pkg::DACPC_ST_IDLE:
        begin
          if (cal_req)
          begin
            st_reg                <= dacpc_pkg::DACPC_ST_CAL;
            o_calibration_running <= 1'b1;
          end
        end
        dacpc_pkg::DACPC_ST_CAL:
        begin
          if (fall_ev)
          begin
            if (cnt_reg == P_CAL_LEN - 32'h1)
            begin
              cnt_reg               <= '0;
              st_reg                <= dacpc_pkg::DACPC_ST_IDLE;
              o_calibration_running <= 1'b0;
            end
            else
              cnt_reg <= cnt_reg + 32'h1;
          end
        end
        default:
        begin
          st_reg                <= dacpc_pkg::DACPC_ST_IDLE;
          o_calibration_running <= 1'b0;
        end
      endcase
    end
  end

  // Q trim is only valid from a calibration that ran with Q powered
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      q_cal_ok_reg <= 1'b0;
    else if (pin_s.q_power_down_input)
      q_cal_ok_reg <= 1'b0;
    else if (st_reg == dacpc_pkg::DACPC_ST_CAL && fall_ev
             && cnt_reg == P_CAL_LEN - 32'h1)
      q_cal_ok_reg <= 1'b1;
  end

  // rise-edge converter sample waits half a period for the next fall
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      rise_hold_reg <= '0;
    else if (rise_ev && !q_down)
      rise_hold_reg <= sel_q ? pin_s.q_sample : pin_s.i_sample;
  end

  assign i_in = (des && sel_q) ? pin_s.q_sample : pin_s.i_sample;
  assign q_in = des ? rise_hold_reg : pin_s.q_sample;

  // conversion pipelines, shifted once per sample-clock fall; cleared
  // at reset so stale words never meet freshly reset buses
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pipe_i[0] <= '0;
      pipe_q[0] <= '0;
    end
    else
    begin
      if (fall_ev && !pwr_off_reg)
        pipe_i[0] <= i_in;
      if (fall_ev && !q_down)
        pipe_q[0] <= q_in;
    end
  end

  for (genvar k = 1; k < `DACPC_PIPE_DEPTH; k++)
  begin : g_pipe
    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
      begin
        pipe_i[k] <= '0;
        pipe_q[k] <= '0;
      end
      else
      begin
        if (fall_ev && !pwr_off_reg)
          pipe_i[k] <= pipe_i[k-1];
        if (fall_ev && !q_down)
          pipe_q[k] <= pipe_q[k-1];
      end
    end
  end

  // taps give 13 and 14 periods; frozen buses hold the last conversion
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_buses <= '0;
    else if (fall_ev && !pwr_off_reg)
    begin
      o_buses.i_primary_bus <= pipe_i[`DACPC_PRI_TAP];
      o_buses.i_delayed_bus <= pipe_i[`DACPC_DLY_TAP];
      if (!q_down)
      begin
        o_buses.q_primary_bus <= pipe_q[`DACPC_PRI_TAP];
        o_buses.q_delayed_bus <= pipe_q[`DACPC_DLY_TAP];
      end
    end
  end

  // data moves on the fall event; clock phase chosen relative to it
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_forwarded_data_clock <= 1'b0;
    else if (ddr)
    begin
      if (fall_ev)
        o_forwarded_data_clock <= ~o_forwarded_data_clock;
    end
    else if (fall_ev)
      o_forwarded_data_clock <= out_edge;
    else if (rise_ev)
      o_forwarded_data_clock <= ~out_edge;
  end

  dacpc_phase_track u_phase (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_enable      (des && bg_en && !q_down),
    .i_strobe      (fall_ev),
    .i_rise_sample (rise_hold_reg),
    .i_fall_sample (i_in),
    .o_trim        (trim)
  );

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_phase_trim          <= `DACPC_TRIM_MID;
      o_output_level_select <= 1'b0;
    end
    else
    begin
      o_phase_trim          <= trim;
      o_output_level_select <= pin_s.ext_control ? ctrl_reg.out_level
                                                 : pin_s.output_level_select;
    end
  end

  // apb slave: one wait state, answer registered
  assign apb_done = i_psel && i_penable && o_pready;

  always_comb
  begin
    status_word = '0;
    status_word[`DACPC_ST_CAL_RUN]  = o_calibration_running;
    status_word[`DACPC_ST_PWR_DOWN] = pwr_off_reg;
    status_word[`DACPC_ST_Q_DOWN]   = q_down;
    status_word[`DACPC_ST_Q_CAL_OK] = q_cal_ok_reg;
    status_word[`DACPC_ST_DES]      = des;
    status_word[`DACPC_ST_TRIM_LSB +: 6] = trim;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end
    else
    begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready
                   && i_paddr != `DACPC_ADDR_CTRL
                   && i_paddr != `DACPC_ADDR_STATUS;
      if (i_psel && i_penable && !o_pready && !i_pwrite)
      begin
        if (i_paddr == `DACPC_ADDR_CTRL)
          o_prdata <= {26'h0, ctrl_reg};
        else if (i_paddr == `DACPC_ADDR_STATUS)
          o_prdata <= status_word;
        else
          o_prdata <= '0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ctrl_reg <= `DACPC_CTRL_RESET;
    else if (apb_done && i_pwrite && i_paddr == `DACPC_ADDR_CTRL)
      ctrl_reg <= i_pwdata[`DACPC_CTRL_W-1:0];
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_cal_blocks_off: assert property (
    st_reg == dacpc_pkg::DACPC_ST_CAL |-> !pwr_off_reg
  ) else $error("power-down taken during calibration");
  a_pwrup_off_hold: assert property (
    st_reg == dacpc_pkg::DACPC_ST_DELAY && pin_s.power_down_input
    |=> $stable(cnt_reg)
  ) else $error("power-up delay advanced while power-down high");
  a_cal_req_drop: assert property (
    st_reg == dacpc_pkg::DACPC_ST_IDLE
    && (pwr_off_reg || pin_s.power_down_input)
    |=> st_reg != dacpc_pkg::DACPC_ST_CAL
  ) else $error("calibration started while powered down");
  a_cal_run_out: assert property (
    o_calibration_running == (st_reg == dacpc_pkg::DACPC_ST_CAL)
  ) else $error("calibration running flag disagrees with state");
  a_off_bus_hold: assert property (
    pwr_off_reg |=> $stable(o_buses)
  ) else $error("output buses changed while powered down");
  a_q_bus_hold: assert property (
    q_down |=> $stable(o_buses.q_primary_bus)
  ) else $error("Q bus changed while Q powered down");
  a_i_delay_chain: assert property (
    fall_ev && !pwr_off_reg
    |=> o_buses.i_delayed_bus == $past(o_buses.i_primary_bus)
  ) else $error("delayed I bus not one period behind primary");
  a_des_rise_in: assert property (
    fall_ev && des && !q_down |=> pipe_q[0] == $past(rise_hold_reg)
  ) else $error("dual-edge Q pipe missed the rise sample");
  a_sdr_edge: assert property (
    fall_ev && !ddr |=> o_forwarded_data_clock == $past(out_edge)
  ) else $error("single rate clock level wrong at data change");
  a_ddr_toggle: assert property (
    fall_ev && ddr |=> o_forwarded_data_clock != $past(o_forwarded_data_clock)
  ) else $error("double rate clock did not toggle with data");
endmodule : dacpc_top
`default_nettype wire

/* verification/dacpc_far.sv */
// far side: free-running sample clock and converter sample values
// assumes the bench reads the logs of values seen at each clock edge
`timescale 1ns/100ps
`default_nettype none
module dacpc_far (
  output var logic       o_sample_clk,
  output var logic [7:0] o_i_sample,
  output var logic [7:0] o_q_sample
);
  int         seed = 32'h312A;
  logic [7:0] fall_i[$];
  logic [7:0] fall_q[$];
  logic [7:0] rise_i[$];
  logic [7:0] rise_q[$];

  // data moves mid-phase so both edges see settled values
  initial
  begin
    o_sample_clk = 1'b0;
    o_i_sample   = 8'h00;
    o_q_sample   = 8'h00;
    #13.3;
    forever
    begin
      #20;
      o_i_sample = 8'($random(seed));
      o_q_sample = 8'($random(seed));
      #20;
      o_sample_clk = ~o_sample_clk;
      if (o_sample_clk)
      begin
        rise_i.push_back(o_i_sample);
        rise_q.push_back(o_q_sample);
      end
      else
      begin
        fall_i.push_back(o_i_sample);
        fall_q.push_back(o_q_sample);
      end
    end
  end
endmodule : dacpc_far
`default_nettype wire

/* verification/dual_adc_output_and_power_control_tb_top.sv */
// bench: pin and APB stimulus, queue model of the output buses
// assumes dacpc_far supplies the sample clock and the sample values
`timescale 1ns/100ps
`include "dacpc_map.svh"
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) \
    begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module dual_adc_output_and_power_control_tb_top;
  localparam logic [31:0] PS = 32'h0000_0020;
  localparam logic [31:0] PL = 32'h0000_0040;
  localparam logic [31:0] PC = 32'h0000_0010;
  logic                         i_clk;
  logic                         i_rst;
  logic                         psel;
  logic                         penable;
  logic                         pwrite;
  logic [`DACPC_ADDR_W-1:0]     paddr;
  logic [31:0]                  pwdata;
  logic [31:0]                  prdata;
  logic                         pready;
  logic                         pslverr;
  logic                         sclk;
  logic [7:0]                   isamp;
  logic [7:0]                   qsamp;
  dacpc_pkg::dacpc_pins_t       ctl;
  dacpc_pkg::dacpc_pins_t       pins;
  dacpc_pkg::dacpc_bus_t        buses;
  logic                         fdc;
  logic                         lvl;
  logic                         cal_run;
  logic [5:0]                   trim;
  logic [31:0]                  rd;
  int                           fails = 0;
  int                           n_checks = 0;
  int                           nw;
  int                           nr;

  assign pins = {sclk, isamp, qsamp, ctl[8:0]};

  dacpc_top #(
    .P_PWRUP_SHORT (PS),
    .P_PWRUP_LONG  (PL),
    .P_CAL_LEN     (PC)
  ) dacpc_top_inst (
    .i_clk                  (i_clk),
    .i_rst                  (i_rst),
    .i_psel                 (psel),
    .i_penable              (penable),
    .i_pwrite               (pwrite),
    .i_paddr                (paddr),
    .i_pwdata               (pwdata),
    .o_prdata               (prdata),
    .o_pready               (pready),
    .o_pslverr              (pslverr),
    .i_pins                 (pins),
    .o_buses                (buses),
    .o_forwarded_data_clock (fdc),
    .o_output_level_select  (lvl),
    .o_calibration_running  (cal_run),
    .o_phase_trim           (trim)
  );

  dacpc_far dacpc_far_inst (
    .o_sample_clk (sclk),
    .o_i_sample   (isamp),
    .o_q_sample   (qsamp)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  // lands just after a clock edge, well clear of the next sample edge
  task automatic falls(input int n);
    repeat (n) @(negedge sclk);
    repeat (6) @(posedge i_clk);
  endtask : falls

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic err);
    int k;
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    `CHK("apb error", err, pslverr)
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      fails++;
      final_report();
    end
  endtask : apb

  task automatic do_reset(input logic ext, input logic off, input logic dly);
    i_rst <= 1'b1;
    ctl   <= {17'h00000, ext, 4'h0, off, 2'b01, dly};
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : do_reset

  task automatic cal_cmd();
    ctl.cal_input <= 1'b0;
    falls(82);
    ctl.cal_input <= 1'b1;
    falls(82);
  endtask : cal_cmd

  task automatic cal_time(input int lim);
    nw = 0;
    nr = 0;
    while (cal_run !== 1'b1 && nw < lim)
    begin
      @(negedge sclk);
      nw++;
    end
    while (cal_run === 1'b1 && nr < lim)
    begin
      @(negedge sclk);
      nr++;
    end
    @(posedge i_clk);
  endtask : cal_time

  // window allows for pin sync latency and the first partial period
  function automatic logic inr(int v, logic [31:0] c);
    return v >= int'(c) - 1 && v <= int'(c) + 2;
  endfunction : inr

  task automatic stream(input int n, input int mode);
    dacpc_pkg::dacpc_bus_t e;
    dacpc_pkg::dacpc_bus_t h;
    int                    k;
    h = buses;
    repeat (n)
    begin
      falls(1);
      k = dacpc_far_inst.fall_i.size() - 1;
      e = {dacpc_far_inst.fall_i[k-13], dacpc_far_inst.fall_i[k-14],
           dacpc_far_inst.fall_q[k-13], dacpc_far_inst.fall_q[k-14]};
      if (mode == 1)
        e[15:0] = {dacpc_far_inst.rise_i[k-13], dacpc_far_inst.rise_i[k-14]};
      if (mode == 2)
        e = {e[15:0], dacpc_far_inst.rise_q[k-13],
             dacpc_far_inst.rise_q[k-14]};
      if (mode == 3)
        e[15:0] = h[15:0];
      if (mode == 4)
        e = h;
      `CHK("buses", e, buses)
    end
  endtask : stream

  task automatic fwd_clk(input int n, input logic ddr, input logic edg);
    logic prev;
    prev = fdc;
    repeat (n)
    begin
      falls(1);
      if (ddr)
        `CHK("ddr fall", ~prev, fdc)
      else
        `CHK("sdr fall", edg, fdc)
      prev = fdc;
      @(posedge sclk);
      repeat (6) @(posedge i_clk);
      if (ddr)
        `CHK("ddr rise", prev, fdc)
      else
        `CHK("sdr rise", ~edg, fdc)
    end
  endtask : fwd_clk

  initial
  begin
    #400000;
    fails++;
    final_report();
  end

  initial
  begin
    i_rst   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = 32'h0;
    ctl     = {17'h00000, 1'b0, 4'h0, 1'b1, 2'b01, 1'b0};
    @(posedge i_clk);
    do_reset(1'b0, 1'b1, 1'b0);
    `CHK("trim reset", `DACPC_TRIM_MID, trim)
    falls(60);
    `CHK("cal held", 1'b0, cal_run)
    ctl.power_down_input <= 1'b0;
    cal_time(200);
    `CHK("pwrup delay", 1'b1, inr(nw, PS))
    `CHK("cal length", 1'b1, inr(nr, PC))
    falls(16);
    stream(10, 0);
    ctl.power_down_input <= 1'b1;
    stream(8, 4);
    ctl.power_down_input <= 1'b0;
    // stale pipeline words are skipped before comparing again
    falls(16);
    stream(4, 0);
    ctl.output_edge_select <= 1'b1;
    falls(2);
    fwd_clk(4, 1'b0, 1'b1);
    ctl.output_edge_select <= 1'b0;
    falls(2);
    fwd_clk(4, 1'b0, 1'b0);
    ctl.output_edge_float <= 1'b1;
    falls(2);
    fwd_clk(4, 1'b1, 1'b0);
    cal_cmd();
    falls(20);
    ctl.des_select          <= 1'b1;
    ctl.output_level_select <= 1'b1;
    falls(16);
    stream(10, 1);
    `CHK("level", 1'b1, lvl)
    ctl.des_select         <= 1'b0;
    ctl.q_power_down_input <= 1'b1;
    falls(16);
    stream(8, 3);
    cal_cmd();
    falls(20);
    apb(1'b0, `DACPC_ADDR_STATUS, 32'h0, 1'b0);
    `CHK("q cal skipped", 1'b0, rd[`DACPC_ST_Q_CAL_OK])
    ctl.q_power_down_input <= 1'b0;
    cal_cmd();
    falls(20);
    apb(1'b0, `DACPC_ADDR_STATUS, 32'h0, 1'b0);
    `CHK("q cal done", 1'b1, rd[`DACPC_ST_Q_CAL_OK])
    cal_cmd();
    ctl.power_down_input <= 1'b1;
    falls(4);
    apb(1'b0, `DACPC_ADDR_STATUS, 32'h0, 1'b0);
    `CHK("off deferred", 2'b01, rd[1:0])
    falls(16);
    apb(1'b0, `DACPC_ADDR_STATUS, 32'h0, 1'b0);
    `CHK("off after cal", 2'b10, rd[1:0])
    cal_cmd();
    ctl.power_down_input <= 1'b0;
    cal_time(100);
    `CHK("cal dropped", 100, nw)
    do_reset(1'b0, 1'b0, 1'b1);
    cal_time(200);
    `CHK("long delay", 1'b1, inr(nw, PL))
    do_reset(1'b1, 1'b0, 1'b1);
    // refused write must leave the control word untouched
    apb(1'b1, 12'h008, 32'h0000_003F, 1'b1);
    apb(1'b0, `DACPC_ADDR_CTRL, 32'h0, 1'b0);
    `CHK("ctrl reset", 32'h0, rd)
    apb(1'b0, 12'h008, 32'h0, 1'b1);
    `CHK("unmapped", 32'h0, rd)
    cal_time(200);
    cal_cmd();
    falls(20);
    apb(1'b1, `DACPC_ADDR_CTRL, 32'h0000_0023, 1'b0);
    falls(16);
    stream(10, 2);
    apb(1'b0, `DACPC_ADDR_STATUS, 32'h0, 1'b0);
    `CHK("des active", 1'b1, rd[`DACPC_ST_DES])
    `CHK("level reg", 1'b1, lvl)
    apb(1'b0, `DACPC_ADDR_CTRL, 32'h0, 1'b0);
    `CHK("ctrl back", 32'h0000_0023, rd)
    final_report();
  end
endmodule : dual_adc_output_and_power_control_tb_top
`default_nettype wire
